// ===== rtl/queued_spi_controller.sv
`timescale 1ns/1ps

// How it works
// - Clock pin is general I/O until enabled, then carries the serial clock.
// - Full duplex on three wires or half duplex on the data-out wire.
// - Word length programmable from eight to sixteen bits.
// - Gap between words 17 clocks by default, up to 8192 clocks.
// - Eighty-byte RAM of receive, transmit and command, open to the processor.
// - Queue of sixteen self-contained entries runs without processor help.
// - Queue pointer steps after each word; processor may rewrite it anytime.
// - Four chip selects come from each command byte.
// - Wrap mode reruns the queue from entry zero, overwriting earlier receive words.
// - Continue bit keeps selects asserted; standard gap is 17 clocks.
// - Processor owns control bits; port logic only clears the enable bit.
// - Rewriting an identical control value changes nothing except the pointer register, which restarts the queue at its start pointer.
// - Pointer register is buffered and applied when the current word ends.
// - A new start pointer restarts the queue at that entry.
// - Pointer reads show the active value, not the pending one.
// - Only the port sets status flags; the processor only clears them.
// - Receive words are right-justified with bits above the length zeroed.
// - Completed pointer shows the last finished entry.
// - Transmit RAM is only read, right-justified, never changed by the port.
// - Sixteen command bytes of select and control fields, never changed.
// - Queue runs from the start pointer through the end pointer.
// - Words shift most significant bit first.
// - End match sets done flag, then stops and clears enable unless wrapping.
// - Slave select asserted while master raises a mode fault.
// - All four clock polarity and phase combinations are supported in master mode; slave mode samples on falling link clock edges only.
module queued_spi_controller
    import qspi_pkg::*;
#(
    parameter int GAP_MAX_CLKS = 8192
) (
    // Clocks and reset
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            link_clk,
    // Configuration and enable
    input  wire port_config_t    port_config,
    input  wire logic [CS_W-1:0] select_idle,
    input  wire logic            enable_write,
    input  wire logic            enable_wdata,
    output logic                 port_enable_bit,
    // Queue pointers
    input  wire logic            queue_pointer_write,
    input  wire queue_pointers_t queue_pointer_wdata,
    output queue_pointers_t      queue_pointer_control_reg,
    // Status
    input  wire logic            status_clear,
    input  wire logic [1:0]      status_clear_mask,
    output logic [PTR_W-1:0]     completed_queue_pointer,
    output logic                 queue_done_flag,
    output logic                 mode_fault,
    // Processor RAM port
    input  wire logic            ram_req,
    input  wire logic            ram_write,
    input  wire logic [1:0]      ram_segment,
    input  wire logic [PTR_W-1:0] ram_index,
    input  wire logic [WORD_W-1:0] ram_wdata,
    output logic [WORD_W-1:0]    ram_rdata,
    // Clock pin as general I/O
    input  wire logic            clock_pin_gpio,
    input  wire logic            clock_pin_gpio_dir,
    // Serial pins
    output logic                 sck_o,
    output logic                 sck_oe_n,
    output logic                 mosi_o,
    output logic                 mosi_oe_n,
    input  wire logic            mosi_i,
    input  wire logic            miso_i,
    output logic                 miso_o,
    output logic                 miso_oe_n,
    input  wire logic            select0_or_slave_select_i,
    output logic                 select0_or_slave_select_o,
    output logic                 select0_or_slave_select_oe_n,
    output logic [CS_W-2:0]      peripheral_selects_upper
);

    // ****************************************************************
    // Elaboration checks and derived constants
    // ****************************************************************
    if (GAP_MAX_CLKS < GAP_STEPS || GAP_MAX_CLKS > 8192 || GAP_MAX_CLKS % GAP_STEPS != 0) begin : g_chk
        $error("GAP_MAX_CLKS must be a multiple of 256 between 256 and 8192");
    end

    localparam logic [GAP_W-1:0] GAP_UNIT = GAP_W'(GAP_MAX_CLKS / GAP_STEPS);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [WORD_W-1:0]    rx_ram  [QUEUE_DEPTH];
    logic [WORD_W-1:0]    tx_ram  [QUEUE_DEPTH];
    logic [CMD_W-1:0]     cmd_ram [QUEUE_DEPTH];

    master_state_t        state;
    logic [PTR_W-1:0]     qptr;
    queue_pointers_t      pending;
    logic                 pending_valid;
    logic                 sck_int;
    logic                 mosi_int;
    logic [CS_W-1:0]      cs_int;
    logic                 cur_cont;
    logic [7:0]           div_cnt;
    logic [LEN_W:0]       edge_cnt;
    logic [LEN_W-1:0]     len;
    logic [WORD_W-1:0]    tx_sh;
    logic [WORD_W-1:0]    rx_sh;
    logic [GAP_W-1:0]     gap_cnt;
    logic [WORD_W-1:0]    slave_tx;
    logic [LEN_W-1:0]     slave_len;
    logic                 miso_s1, miso_s2, mosi_s1, mosi_s2, sel_s1, sel_s2;
    logic                 tog_s1, tog_s2, tog_s3;

    // Link side, clocked only by the external master's clock.
    logic                 lrst_s1, lrst_s2;
    logic [LEN_W-1:0]     sl_cnt;
    logic [WORD_W-1:0]    sl_rx;
    logic [WORD_W-1:0]    sl_word;
    logic                 sl_toggle;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    // level config, rewrite harmless.
    wire command_t         cmd_now      = command_t'(cmd_ram[qptr]);
    wire logic [LEN_W-1:0] len_now      = transfer_length(cmd_now.bitse, port_config.bits);
    wire logic [7:0]       half_period  = (port_config.baud < MIN_HALF_PERIOD) ?
                                          MIN_HALF_PERIOD : port_config.baud;
    wire logic             master_on    = port_enable_bit & port_config.master;
    wire logic             slave_on     = port_enable_bit & ~port_config.master;
    wire logic             div_hit      = (div_cnt == half_period - 8'h01);
    wire logic             last_edge    = (edge_cnt == {len, 1'b0} - 6'h01);
    wire logic             leading      = ~edge_cnt[0];
    wire logic             sample_edge  = div_hit & (leading ^ port_config.cpha);
    wire logic             drive_edge   = div_hit & ~(leading ^ port_config.cpha) & ~last_edge;
    wire logic             din          = (port_config.half_duplex & port_config.half_duplex_rx) ?
                                          mosi_s2 : miso_s2;
    wire logic [WORD_W-1:0] rx_sampled  = {rx_sh[WORD_W-2:0], din};
    wire logic             master_done  = (state == ST_SHIFT) & div_hit & last_edge;
    wire logic             slave_done   = slave_on & (tog_s2 ^ tog_s3);
    wire logic             word_done    = master_done | slave_done;
    wire logic [WORD_W-1:0] rx_word     = master_done ?
                                          ((sample_edge ? rx_sampled : rx_sh) & length_mask(len)) :
                                          (sl_word & length_mask(slave_len));
    wire logic             at_end       = (qptr == queue_pointer_control_reg.end_qp);
    wire logic             stop_now     = word_done & at_end & ~port_config.wrap;
    wire logic             busy         = (state == ST_LOAD) | (state == ST_SHIFT) | slave_on;
    wire logic             apply_ptr    = pending_valid & (word_done | ~busy);
    wire logic             start_enable = enable_write & enable_wdata & ~port_enable_bit;
    wire logic [PTR_W-1:0] step_ptr     = at_end ? PTR_RESET : qptr + 4'h1;
    wire logic [GAP_W-1:0] gap_load     = ~cmd_now.dt ? STD_GAP_CLKS :
                                          (port_config.dtl == 8'h00) ? GAP_W'(GAP_UNIT * GAP_STEPS_ZERO)
                                          : GAP_W'(GAP_UNIT * {1'b0, port_config.dtl});
    wire logic [WORD_W-1:0] tx_aligned  = tx_ram[qptr] << (BITS_MAX - len_now);
    wire logic             cpu_rx_we    = ram_req & ram_write & (ram_segment == SEG_RX);
    wire logic             rx_clash     = word_done & (ram_index == qptr);
    wire logic [LEN_W-1:0] slave_bit    = slave_len - 5'h01 - sl_cnt;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always_ff @(posedge clk) begin
        miso_s1 <= miso_i;
        miso_s2 <= miso_s1;
        mosi_s1 <= mosi_i;
        mosi_s2 <= mosi_s1;
        sel_s1  <= select0_or_slave_select_i;
        sel_s2  <= sel_s1;
        tog_s1  <= sl_toggle;
        tog_s2  <= tog_s1;
        tog_s3  <= tog_s2;
    end

    // ****************************************************************
    // Enable, pointers and status
    // ****************************************************************
    // only clears enable.
    always_ff @(posedge clk) begin
        if (rst) begin
            port_enable_bit <= 1'b0;
        end else if (enable_write) begin
            port_enable_bit <= enable_wdata;
        end else if (stop_now) begin
            port_enable_bit <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            queue_pointer_control_reg <= '0;
            pending                   <= '0;
            pending_valid             <= 1'b0;
        end else begin
            if (apply_ptr) begin
                queue_pointer_control_reg <= pending;
                pending_valid             <= 1'b0;
            end
            if (queue_pointer_write) begin
                pending       <= queue_pointer_wdata;
                pending_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            qptr <= PTR_RESET;
        end else if (apply_ptr) begin
            qptr <= pending.new_qp;
        end else if (start_enable) begin
            qptr <= queue_pointer_control_reg.new_qp;
        end else if (word_done) begin
            qptr <= step_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            completed_queue_pointer <= PTR_RESET;
        end else if (word_done) begin
            completed_queue_pointer <= qptr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            queue_done_flag <= 1'b0;
            mode_fault      <= 1'b0;
        end else begin
            queue_done_flag <= (word_done & at_end) |
                               (queue_done_flag & ~(status_clear & status_clear_mask[CLR_DONE_BIT]));
            mode_fault      <= (master_on & ~sel_s2) |
                               (mode_fault & ~(status_clear & status_clear_mask[CLR_FAULT_BIT]));
        end
    end

    // ****************************************************************
    // Queue RAM
    // ****************************************************************
    // same index receive.
    always_ff @(posedge clk) begin
        if (word_done) begin
            rx_ram[qptr] <= rx_word;
        end
        if (cpu_rx_we & ~rx_clash) begin
            rx_ram[ram_index] <= ram_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (ram_req & ram_write & (ram_segment == SEG_TX)) begin
            tx_ram[ram_index] <= ram_wdata;
        end
        if (ram_req & ram_write & (ram_segment == SEG_CMD)) begin
            cmd_ram[ram_index] <= ram_wdata[CMD_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ram_rdata <= '0;
        end else if (ram_req & ~ram_write) begin
            unique case (ram_segment)
                SEG_RX:  ram_rdata <= rx_ram[ram_index];
                SEG_TX:  ram_rdata <= tx_ram[ram_index];
                SEG_CMD: ram_rdata <= {8'h00, cmd_ram[ram_index]};
                default: ram_rdata <= '0;
            endcase
        end
    end

    // ****************************************************************
    // Master sequencer
    // ****************************************************************
    // queue runs unaided.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (~master_on) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE:  state <= ST_LOAD;
                ST_LOAD:  state <= ST_SHIFT;
                ST_SHIFT: state <= master_done ? (stop_now ? ST_IDLE : ST_GAP) : ST_SHIFT;
                ST_GAP:   state <= (gap_cnt == 14'h0001) ? ST_LOAD : ST_GAP;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gap_cnt <= '0;
        end else if (master_done) begin
            gap_cnt <= gap_load;
        end else if (state == ST_GAP) begin
            gap_cnt <= gap_cnt - 14'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state != ST_SHIFT || div_hit) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            len      <= BITS_DEFAULT;
            edge_cnt <= '0;
            sck_int  <= 1'b0;
        end else if (state == ST_LOAD) begin
            len      <= len_now;
            edge_cnt <= '0;
            sck_int  <= port_config.cpol;
        end else if (state == ST_SHIFT && div_hit) begin
            edge_cnt <= edge_cnt + 6'h01;
            sck_int  <= ~sck_int;
        end else if (state != ST_SHIFT) begin
            sck_int  <= port_config.cpol;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_sh    <= '0;
            rx_sh    <= '0;
            mosi_int <= 1'b0;
        end else if (state == ST_LOAD) begin
            rx_sh    <= '0;
            tx_sh    <= port_config.cpha ? tx_aligned : (tx_aligned << 1);
            mosi_int <= port_config.cpha ? mosi_int : tx_aligned[WORD_W-1];
        end else if (state == ST_SHIFT) begin
            if (sample_edge) begin
                rx_sh <= rx_sampled;
            end
            if (drive_edge) begin
                mosi_int <= tx_sh[WORD_W-1];
                tx_sh    <= tx_sh << 1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_int   <= '1;
            cur_cont <= 1'b0;
        end else if (state == ST_LOAD) begin
            cs_int   <= cmd_now.cs;
            cur_cont <= cmd_now.cont;
        end else if (~master_on || stop_now || (master_done && !cur_cont) || state == ST_IDLE) begin
            cs_int   <= select_idle;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // clock pin ownership.
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_o    <= 1'b0;
            sck_oe_n <= 1'b1;
        end else begin
            sck_o    <= master_on ? sck_int : clock_pin_gpio;
            sck_oe_n <= ~(master_on | (~port_enable_bit & clock_pin_gpio_dir));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mosi_o                       <= 1'b0;
            mosi_oe_n                    <= 1'b1;
            miso_oe_n                    <= 1'b1;
            select0_or_slave_select_o    <= 1'b1;
            select0_or_slave_select_oe_n <= 1'b1;
            peripheral_selects_upper     <= '1;
        end else begin
            mosi_o                       <= mosi_int;
            mosi_oe_n                    <= ~(master_on & ~(port_config.half_duplex &
                                                            port_config.half_duplex_rx));
            miso_oe_n                    <= ~(slave_on & ~sel_s2);
            select0_or_slave_select_o    <= cs_int[0];
            select0_or_slave_select_oe_n <= ~master_on;
            peripheral_selects_upper     <= cs_int[CS_W-1:1];
        end
    end

    // Slave word and length are recopied from the current entry every clock; the link side
    // reads the word on every rising link clock edge, selected or not.
    always_ff @(posedge clk) begin
        if (rst) begin
            slave_tx  <= '0;
            slave_len <= BITS_DEFAULT;
        end else begin
            slave_tx  <= tx_ram[qptr];
            slave_len <= len_now;
        end
    end

    // ****************************************************************
    // Link clock domain (slave mode)
    // ****************************************************************
    always_ff @(posedge link_clk) begin
        lrst_s1 <= rst;
        lrst_s2 <= lrst_s1;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_s2) begin
            miso_o <= 1'b0;
        end else begin
            miso_o <= slave_tx[slave_bit[3:0]];
        end
    end

    always_ff @(negedge link_clk) begin
        if (lrst_s2) begin
            sl_cnt    <= '0;
            sl_rx     <= '0;
            sl_word   <= '0;
            sl_toggle <= 1'b0;
        end else if (!select0_or_slave_select_i) begin
            sl_rx <= (sl_cnt == 5'h00) ? {15'h0000, mosi_i} : {sl_rx[WORD_W-2:0], mosi_i};
            if (sl_cnt == slave_len - 5'h01) begin
                sl_word   <= {sl_rx[WORD_W-2:0], mosi_i};
                sl_toggle <= ~sl_toggle;
                sl_cnt    <= '0;
            end else begin
                sl_cnt <= sl_cnt + 5'h01;
            end
        end
    end

endmodule : queued_spi_controller

// ===== rtl/qspi_pkg.sv
// ********************************************************************
// Shared constants and types for the queued serial port.
// ********************************************************************
package qspi_pkg;

    localparam int          QUEUE_DEPTH     = 16;
    localparam int          PTR_W           = 4;
    localparam int          WORD_W          = 16;
    localparam int          CMD_W           = 8;
    localparam int          CS_W            = 4;
    localparam int          LEN_W           = 5;
    localparam int          GAP_W           = 14;
    localparam int          GAP_STEPS       = 256;

    localparam logic [LEN_W-1:0] BITS_DEFAULT    = 5'h08;
    localparam logic [LEN_W-1:0] BITS_MAX        = 5'h10;
    localparam logic [3:0]       BITS_FIELD_MIN  = 4'h9;
    localparam logic [3:0]       BITS_FIELD_FULL = 4'h0;
    localparam logic [GAP_W-1:0] STD_GAP_CLKS    = 14'h0011;
    localparam logic [8:0]       GAP_STEPS_ZERO  = 9'h100;
    localparam logic [7:0]       MIN_HALF_PERIOD = 8'h02;
    localparam logic [PTR_W-1:0] PTR_RESET       = 4'h0;

    // Segment codes of the processor RAM port.
    localparam logic [1:0]  SEG_RX          = 2'h0;
    localparam logic [1:0]  SEG_TX          = 2'h1;
    localparam logic [1:0]  SEG_CMD         = 2'h2;

    // Bit positions of the status clear mask.
    localparam int          CLR_DONE_BIT    = 0;
    localparam int          CLR_FAULT_BIT   = 1;

    // One command byte: continue, length select, delay select, spare, selects.
    typedef struct packed {
        logic            cont;
        logic            bitse;
        logic            dt;
        logic            spare;
        logic [CS_W-1:0] cs;
    } command_t;

    typedef struct packed {
        logic       master;
        logic       cpol;
        logic       cpha;
        logic       wrap;
        logic       half_duplex;
        logic       half_duplex_rx;
        logic [3:0] bits;
        logic [7:0] baud;
        logic [7:0] dtl;
    } port_config_t;

    typedef struct packed {
        logic [PTR_W-1:0] new_qp;
        logic [PTR_W-1:0] end_qp;
    } queue_pointers_t;

    typedef enum {ST_IDLE, ST_LOAD, ST_SHIFT, ST_GAP} master_state_t;

    // Bits per word from the command's length select and the length field.
    function automatic logic [LEN_W-1:0] transfer_length(input logic bitse,
                                                         input logic [3:0] bits);
        if (!bitse) begin
            return BITS_DEFAULT;
        end
        if (bits == BITS_FIELD_FULL) begin
            return BITS_MAX;
        end
        if (bits >= BITS_FIELD_MIN) begin
            return {1'b0, bits};
        end
        return BITS_DEFAULT;
    endfunction : transfer_length

    // Mask keeping the low len bits of a word.
    function automatic logic [WORD_W-1:0] length_mask(input logic [LEN_W-1:0] len);
        logic [WORD_W:0] full;
        full = (17'h00001 << len) - 17'h00001;
        return full[WORD_W-1:0];
    endfunction : length_mask

endpackage : qspi_pkg

// ===== verification/qspi_sva.sv
`timescale 1ns/1ps
// ********
// Port checker.
// ********
module qspi_sva import qspi_pkg::*; (
    input wire logic clk, rst, enable_write, enable_wdata, port_enable_bit,
    input wire logic queue_pointer_write, status_clear, queue_done_flag, mode_fault,
    input wire logic select0_or_slave_select_i, select0_or_slave_select_o,
    input wire port_config_t port_config,
    input wire queue_pointers_t queue_pointer_wdata, queue_pointer_control_reg,
    input wire logic [1:0] status_clear_mask,
    input wire logic [3:0] select_idle, completed_queue_pointer,
    input wire logic [2:0] peripheral_selects_upper
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_en; enable_write |=> port_enable_bit == $past(enable_wdata); endproperty
    a_en: assert property (p_en) else $error("enable write lost");
    property p_qp; queue_pointer_write && !port_enable_bit
        |-> ##2 queue_pointer_control_reg == $past(queue_pointer_wdata, 2); endproperty
    a_qp: assert property (p_qp) else $error("idle pointer not applied");
    property p_dp; $rose(queue_done_flag)
        |-> completed_queue_pointer == queue_pointer_control_reg.end_qp; endproperty
    a_dp: assert property (p_dp) else $error("done off end pointer");
    property p_st; $rose(queue_done_flag) && !port_config.wrap |-> ##[0:2] !port_enable_bit;
    endproperty
    a_st: assert property (p_st) else $error("no stop at end");
    property p_wr; $rose(queue_done_flag) && port_config.wrap && !$past(enable_write)
        |-> port_enable_bit; endproperty
    a_wr: assert property (p_wr) else $error("wrap stopped");
    property p_mf; (port_enable_bit && port_config.master && !select0_or_slave_select_i) [*4]
        |=> mode_fault; endproperty
    a_mf: assert property (p_mf) else $error("no mode fault");
    property p_cl; status_clear && status_clear_mask[0] && !port_enable_bit
        |=> !queue_done_flag; endproperty
    a_cl: assert property (p_cl) else $error("done not cleared");
    property p_sl; $fell(port_enable_bit) && queue_done_flag
        |-> ##2 {peripheral_selects_upper, select0_or_slave_select_o} == select_idle; endproperty
    a_sl: assert property (p_sl) else $error("selects not idle");
endmodule : qspi_sva
bind queued_spi_controller qspi_sva qspi_sva_i (.*);

// ===== verification/spi_peer.sv
`timescale 1ns/1ps
// ********
// Peripheral answering a fixed word.
// ********
module spi_peer (
    input  wire logic   sck,
    input  wire logic   mosi,
    input  wire logic   sel_n,
    output logic        miso,
    output logic [15:0] got
);
    localparam logic [15:0] PAT = 16'hc35a;
    logic [3:0] n = 4'h0;
    initial got = 16'h0000;
    // A released line drives the inverted last received bit, not pattern data.
    assign miso = sel_n ? ~got[0] : PAT[~n];
    always @(posedge sck or posedge sel_n) begin
        if (sel_n) begin
            n <= 4'h0;
        end else begin
            got <= {got[14:0], mosi};
            n <= n + 4'h1;
        end
    end
endmodule : spi_peer

// ===== verification/tb_top.sv
`timescale 1ns/1ps
// ********
// Queue, wrap and fault tests.
// ********
module tb_top import qspi_pkg::*;;
    logic clk = 0, rst = 1, lc = 0, lk = 1, ew = 0, ed = 0, qw = 0, sc = 0, rq = 0, rw = 0;
    logic ss = 1, en, dn, mf, sk, mo, mi;
    logic [1:0] sg = 2'h0;
    logic [2:0] up;
    logic [3:0] ix = 4'h0, cq;
    logic [15:0] wd = 16'h0000, rd, got;
    port_config_t cf = 26'h2000200;
    queue_pointers_t qd = 8'h01, qp;
    int mismatches = 0, checks = 0, i;
    initial forever #10 clk = ~clk;
    initial forever #40 lc = lk & ~lc;
    queued_spi_controller #(.GAP_MAX_CLKS(256)) queued_spi_controller_i (.clk(clk), .rst(rst),
        .link_clk(lc), .port_config(cf), .select_idle(4'hf), .enable_write(ew),
        .enable_wdata(ed), .port_enable_bit(en), .queue_pointer_write(qw),
        .queue_pointer_wdata(qd), .queue_pointer_control_reg(qp), .status_clear(sc),
        .status_clear_mask(2'h1), .completed_queue_pointer(cq), .queue_done_flag(dn),
        .mode_fault(mf), .ram_req(rq), .ram_write(rw), .ram_segment(sg), .ram_index(ix),
        .ram_wdata(wd), .ram_rdata(rd), .clock_pin_gpio(1'b0), .clock_pin_gpio_dir(1'b1),
        .sck_o(sk), .sck_oe_n(), .mosi_o(mo), .mosi_oe_n(), .mosi_i(mo), .miso_i(mi),
        .miso_o(), .miso_oe_n(), .select0_or_slave_select_i(ss),
        .select0_or_slave_select_o(), .select0_or_slave_select_oe_n(),
        .peripheral_selects_upper(up));
    spi_peer spi_peer_i (.sck(sk), .mosi(mo), .sel_n(up[0]), .miso(mi), .got(got));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic ram(input logic w, input logic [1:0] s, input logic [3:0] x,
                       input logic [15:0] d);
        {rq, rw, sg, ix, wd} = {1'b1, w, s, x, d};
        @(negedge clk) rq = 1'b0;
        @(negedge clk);
    endtask : ram
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask : pulse
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_done();
        for (i = 0; i < 4000 && dn !== 1'b1; i++) @(negedge clk);
        if (dn !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : wait_done
    initial begin
        repeat (5) @(negedge clk);
        {rst, lk} = 2'h0;
        @(negedge clk);
        ram(1'b1, SEG_TX, 4'h0, 16'h1234);
        ram(1'b1, SEG_TX, 4'h1, 16'hbeef);
        ram(1'b1, SEG_CMD, 4'h0, 16'h000d);
        ram(1'b1, SEG_CMD, 4'h1, 16'h004d);
        pulse(qw);
        ed = 1'b1;
        pulse(ew);
        wait_done();
        repeat (3) @(negedge clk);
        chk(en, 16'h0, "enable");
        chk(cq, 16'h1, "completed");
        chk(qp, 16'h01, "pointers");
        chk(got, 16'hbeef, "mosi");
        ram(1'b0, SEG_RX, 4'h0, 16'h0);
        chk(rd, 16'h00c3, "rx0");
        ram(1'b0, SEG_RX, 4'h1, 16'h0);
        chk(rd, 16'hc35a, "rx1");
        ram(1'b0, SEG_TX, 4'h1, 16'h0);
        chk(rd, 16'hbeef, "tx1");
        pulse(sc);
        chk(dn, 16'h0, "done");
        $display("test queue finished");
        cf = 26'h2400200;
        qd = 8'h11;
        pulse(qw);
        pulse(ew);
        wait_done();
        chk(en, 16'h1, "wrap");
        ss = 1'b0;
        repeat (6) @(negedge clk);
        chk(mf, 16'h1, "fault");
        ed = 1'b0;
        pulse(ew);
        chk(en, 16'h0, "off");
        $display("test wrap finished");
        repeat (4) @(negedge clk);
        tally_and_finish();
    end
endmodule : tb_top
